// ---- dhs_pkg.sv ----
// Package of constants and types for the dog mode homing sequencer
package dhs_pkg;
   // ==========================================================
   // Setting encodings
   localparam logic [3:0] DHS_MODE_DOG = 4'h0;
   localparam logic DHS_DIR_INC = 1'b0;
   localparam logic DHS_POL_HIGH = 1'b1;
   // ==========================================================
   // Widths and limits
   localparam int DHS_SPEED_W = 16;
   localparam int DHS_OFFSET_W = 16;
   localparam int DHS_COORD_W = 16;
   localparam int DHS_POS_W = 32;
   localparam logic [15:0] DHS_OFFSET_MAX = 16'hffff;
   // Reset values
   localparam logic [DHS_POS_W-1:0] DHS_POS_RST = 32'h0000_0000;
   localparam logic [DHS_SPEED_W-1:0] DHS_SPEED_RST = 16'h0000;
   // Multiplier factors for codes 0..3
   localparam logic [15:0] DHS_MUL_1 = 16'h0001;
   localparam logic [15:0] DHS_MUL_10 = 16'h000a;
   localparam logic [15:0] DHS_MUL_100 = 16'h0064;
   localparam logic [15:0] DHS_MUL_1000 = 16'h03e8;

   // ==========================================================
   // Power-cycle settings, carried as one group
   typedef struct packed
   {
      logic [3:0] homing_mode_setting;
      logic homing_direction_setting;
      logic proximity_polarity_setting;
      logic [1:0] feed_length_multiplier;
      logic [DHS_SPEED_W-1:0] return_speed_setting;
      logic [DHS_SPEED_W-1:0] creep_speed_setting;
      logic [DHS_OFFSET_W-1:0] home_offset_setting;
      logic signed [DHS_COORD_W-1:0] home_coordinate_setting;
   } dhs_cfg_t;

   // Sequencer states, one-hot
   typedef enum logic [4:0]
   {
      DHS_IDLE = 5'b00001,
      DHS_FAST = 5'b00010,
      DHS_CREEP = 5'b00100,
      DHS_SHIFT = 5'b01000,
      DHS_DONE = 5'b10000
   } dhs_state_t;

   // Scale home coordinate by the multiplier code
   function automatic logic signed [DHS_POS_W-1:0] dhs_scale
   (
      input logic signed [DHS_COORD_W-1:0] coord,
      input logic [1:0] code
   );
      logic [15:0] mul;
      logic signed [DHS_POS_W-1:0] prod;
      mul = DHS_MUL_1;
      unique case (code)
         2'h0: mul = DHS_MUL_1;
         2'h1: mul = DHS_MUL_10;
         2'h2: mul = DHS_MUL_100;
         2'h3: mul = DHS_MUL_1000;
      endcase
      prod = DHS_POS_W'(coord) * $signed({16'h0000, mul});
      return prod;
   endfunction : dhs_scale
endpackage : dhs_pkg

// ---- dhs_reset_sync.sv ----
// Reset release synchroniser for the homing sequencer
module dhs_reset_sync
(
   input wire logic clock,
   input wire logic rst_b,
   output logic rst_sync_b
);
   logic meta_q;
   logic sync_q;

   // ==========================================================
   // Release through two flops; assertion stays asynchronous
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else
      begin
         meta_q <= 1'b1;
         sync_q <= meta_q;
      end
   end

   assign rst_sync_b = sync_q;
endmodule : dhs_reset_sync

// ---- dhs_homing_seq.sv ----
// Dog mode home position return sequencer
// Behaviour
// [RULE_01] Return speed until dog, then creep
// [RULE_02] Polarity setting picks active dog level
// [RULE_03] Home lies offset past Z, homing direction
// [RULE_04] Position loaded with home coordinate at end
// [RULE_05] Reference is Z pulse seen during dog
// [RULE_06] Offset accepts 0 through 65535 micrometres
// [RULE_07] Travel offset at creep, stop, then complete
// [RULE_08] Completion raises homing complete flag
// [RULE_09] Mode value 0 selects dog homing
// [RULE_10] Direction 0 counts up, 1 counts down
// [RULE_11] Multiplier codes give 1,10,100,1000
module dhs_homing_seq
   import dhs_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire dhs_pkg::dhs_cfg_t cfg,
   input wire logic start,
   input wire logic dog_in,
   input wire logic z_pulse,
   input wire logic enc_step,
   output logic [dhs_pkg::DHS_SPEED_W-1:0] speed_cmd,
   output logic dir_down,
   output logic busy,
   output logic homing_complete_flag,
   output logic signed [dhs_pkg::DHS_POS_W-1:0] current_position
);
   import dhs_pkg::*;

   logic rst_sync_b;
   dhs_state_t state_q, state_d;
   logic [DHS_OFFSET_W-1:0] shift_q, shift_d;
   logic [DHS_SPEED_W-1:0] speed_q, speed_d;
   logic done_q, done_d;
   logic signed [DHS_POS_W-1:0] pos_q, pos_d;
   logic dog_active;
   logic mode_ok;

   // ==========================================================
   // Reset
   dhs_reset_sync u_rst
   (
      .clock(clock),
      .rst_b(rst_b),
      .rst_sync_b(rst_sync_b)
   );

   // ==========================================================
   // Input qualification
   assign dog_active = (dog_in == cfg.proximity_polarity_setting); // RULE_02
   assign mode_ok = (cfg.homing_mode_setting == DHS_MODE_DOG); // RULE_09

   // ==========================================================
   // Sequencer next state
   always_comb
   begin
      state_d = state_q;
      shift_d = shift_q;
      speed_d = speed_q;
      done_d = done_q;
      pos_d = pos_q;
      // Position tracks encoder steps in the homing direction
      if (enc_step)
      begin
         if (cfg.homing_direction_setting == DHS_DIR_INC) // RULE_10
            pos_d = pos_q + 32'sd1;
         else
            pos_d = pos_q - 32'sd1;
      end
      unique case (state_q)
         DHS_IDLE:
         begin
            speed_d = DHS_SPEED_RST;
            if (start && mode_ok) // RULE_09
            begin
               done_d = 1'b0;
               speed_d = cfg.return_speed_setting; // RULE_01
               state_d = DHS_FAST;
            end
         end
         DHS_FAST:
         begin
            if (dog_active)
            begin
               speed_d = cfg.creep_speed_setting; // RULE_01
               state_d = DHS_CREEP;
            end
         end
         DHS_CREEP:
         begin
            // Z only counts while dog is still active
            if (z_pulse && dog_active) // RULE_05
            begin
               shift_d = cfg.home_offset_setting; // RULE_06
               state_d = DHS_SHIFT;
               if (cfg.home_offset_setting == 16'h0000)
               begin
                  speed_d = DHS_SPEED_RST;
                  state_d = DHS_DONE;
               end
            end
         end
         DHS_SHIFT:
         begin
            // Offset walked out in encoder steps past Z
            if (enc_step) // RULE_03
               shift_d = shift_q - 16'h0001;
            if (enc_step && shift_q == 16'h0001)
            begin
               speed_d = DHS_SPEED_RST; // RULE_07
               state_d = DHS_DONE;
            end
         end
         DHS_DONE:
         begin
            // Load coordinate after motion has stopped
            pos_d = dhs_scale(cfg.home_coordinate_setting,
                              cfg.feed_length_multiplier); // RULE_04 RULE_11
            done_d = 1'b1; // RULE_08
            state_d = DHS_IDLE;
         end
         default:
         begin
            speed_d = DHS_SPEED_RST;
            state_d = DHS_IDLE;
         end
      endcase
   end

   // Register the sequencer state
   always_ff @(posedge clock or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         state_q <= DHS_IDLE;
         shift_q <= 16'h0000;
         speed_q <= DHS_SPEED_RST;
         done_q <= 1'b0;
         pos_q <= DHS_POS_RST;
      end
      else
      begin
         state_q <= state_d;
         shift_q <= shift_d;
         speed_q <= speed_d;
         done_q <= done_d;
         pos_q <= pos_d;
      end
   end

   // ==========================================================
   // Outputs
   assign speed_cmd = speed_q;
   assign dir_down = cfg.homing_direction_setting; // RULE_10
   assign busy = (state_q != DHS_IDLE);
   assign homing_complete_flag = done_q;
   assign current_position = pos_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_sync_b);

   fast_to_creep_a: assert property ( // RULE_01
      state_q == DHS_FAST && dog_active |=>
      speed_cmd == $past(cfg.creep_speed_setting))
      else $error("creep speed not taken on dog");
   start_fast_a: assert property ( // RULE_01
      state_q == DHS_IDLE && start && mode_ok |=>
      state_q == DHS_FAST && speed_cmd == $past(cfg.return_speed_setting))
      else $error("return speed not taken on start");
   dog_pol_a: assert property ( // RULE_02
      state_q == DHS_FAST && dog_in != cfg.proximity_polarity_setting
      |=> state_q == DHS_FAST)
      else $error("inactive dog level left fast phase");
   z_needs_dog_a: assert property ( // RULE_05
      state_q == DHS_CREEP && !dog_active |=> state_q == DHS_CREEP)
      else $error("Z taken without dog");
   shift_count_a: assert property ( // RULE_03
      state_q == DHS_SHIFT && enc_step && shift_q > 16'h0001 |=>
      shift_q == $past(shift_q) - 16'h0001 && speed_cmd != 16'h0000 ||
      speed_cmd == 16'h0000 && $past(speed_cmd) == 16'h0000)
      else $error("offset count slipped");
   stop_then_done_a: assert property ( // RULE_07
      state_q == DHS_DONE |-> speed_cmd == DHS_SPEED_RST ##1
      homing_complete_flag)
      else $error("complete without stop");
   coord_load_a: assert property ( // RULE_04
      $rose(homing_complete_flag) |-> current_position ==
      dhs_scale($past(cfg.home_coordinate_setting),
                $past(cfg.feed_length_multiplier)))
      else $error("home coordinate not loaded");
   mode_gate_a: assert property ( // RULE_09
      state_q == DHS_IDLE && !mode_ok |=> state_q == DHS_IDLE)
      else $error("homing started in wrong mode");
   dir_count_a: assert property ( // RULE_10
      enc_step && state_q != DHS_DONE && !dir_down |=>
      current_position == $past(current_position) + 32'sd1)
      else $error("up count wrong");
   // Flag only drops on an accepted start; offset latched on Z
   flag_hold_a: assert property ( // RULE_08
      homing_complete_flag && !(state_q == DHS_IDLE && start && mode_ok)
      |=> homing_complete_flag)
      else $error("complete flag dropped without start");
   offset_load_a: assert property ( // RULE_06
      state_q == DHS_CREEP && z_pulse && dog_active &&
      cfg.home_offset_setting != 16'h0000 |=>
      state_q == DHS_SHIFT && shift_q == $past(cfg.home_offset_setting))
      else $error("offset not loaded on Z");

   // Covers for the main paths
   cover_dog_c: cover property (state_q == DHS_FAST ##1
                                state_q == DHS_CREEP);
   // Zero offset skips the shift phase
   cover_zero_c: cover property (state_q == DHS_CREEP ##1
                                 state_q == DHS_DONE);
   // Offset walked out while counting down
   cover_down_c: cover property (state_q == DHS_SHIFT && dir_down);
   cover_shift_c: cover property (state_q == DHS_SHIFT);
   cover_done_c: cover property ($rose(homing_complete_flag));
endmodule : dhs_homing_seq

// ---- dhs_axis_model.sv ----
// Model of the proximity dog switch and motor encoder
module dhs_axis_model
   import dhs_pkg::*;
(
   input wire logic clock,
   input wire logic [dhs_pkg::DHS_SPEED_W-1:0] speed_cmd,
   input wire logic polarity,
   input wire logic [7:0] dog_start,
   output logic dog_in = 1'b0,
   output logic z_pulse = 1'b0,
   output logic enc_step = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Axis motion
   // Below this speed steps come half as often
   localparam logic [15:0] SLOW_LIM = 16'h0100;
   localparam logic [15:0] DOG_LEN = 16'h0008;
   logic [15:0] pos = 16'h0000;
   logic [1:0] ph = 2'h0;
   logic dog_act;
   // Z on the quiet cycle after a step, so it never meets one
   always @(negedge clock)
   begin
      z_pulse <= enc_step && (pos % 6 == 0) && (speed_cmd != 16'h0000);
      enc_step <= 1'b0;
      ph <= ph + 2'h1;
      if (speed_cmd == 16'h0000)
      begin
         pos <= 16'h0000;
         ph <= 2'h0;
      end
      else if (ph == 2'h0 || (ph == 2'h2 && speed_cmd >= SLOW_LIM))
      begin
         enc_step <= 1'b1;
         pos <= pos + 16'h0001;
      end
      dog_act = pos >= {8'h00, dog_start} && pos < dog_start + DOG_LEN;
      dog_in <= dog_act ? polarity : ~polarity;
   end
endmodule : dhs_axis_model

// ---- dhs_homing_seq_tb_top.sv ----
// Self-checking bench for the dog mode homing sequencer
module dhs_homing_seq_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import dhs_pkg::*;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic start = 1'b0;
   dhs_cfg_t cfg = '0;
   logic dog_in, z_pulse, enc_step, dir_down, busy, flag;
   logic [15:0] speed_cmd, spd_exp;
   logic signed [31:0] cur_pos, pos0, pos_exp;
   logic [7:0] dog_start = 8'h03;
   logic zseen = 1'b0;
   int seed = 32'hac7b;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int run_n, steps;
   // ==========================================================
   // Design and far side
   always #50 clock = ~clock;
   dhs_homing_seq DUT (.clock(clock), .rst_b(rst_b), .cfg(cfg),
      .start(start), .dog_in(dog_in), .z_pulse(z_pulse),
      .enc_step(enc_step), .speed_cmd(speed_cmd), .dir_down(dir_down),
      .busy(busy), .homing_complete_flag(flag), .current_position(cur_pos));
   dhs_axis_model axis (.clock(clock), .speed_cmd(speed_cmd),
      .polarity(cfg.proximity_polarity_setting), .dog_start(dog_start),
      .dog_in(dog_in), .z_pulse(z_pulse), .enc_step(enc_step));
   // ==========================================================
   // Checking
   task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_word
   task automatic chk_bit(string nm, logic e, logic g);
      chk_word(nm, {31'h0, e}, {31'h0, g});
   endtask : chk_bit
   function automatic logic [31:0] exp_pos(logic signed [15:0] c,
                                           logic [1:0] k);
      int f;
      f = (k == 2'h0) ? 1 : (k == 2'h1) ? 10 : (k == 2'h2) ? 100 : 1000;
      return 32'(int'(c) * f);
   endfunction : exp_pos
   task automatic conclude();
      if (err_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   // Cycle ceiling; a hang ends the run as a failure
   always @(negedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         err_count++;
         conclude();
      end
   end
   // Watch at the falling edge: design outputs have settled, and the
   // far side still shows what the design sampled at the rising edge
   always @(negedge clock)
   begin
      if (busy === 1'b1 && !zseen && z_pulse === 1'b1 &&
          dog_in === cfg.proximity_polarity_setting)
      begin
         zseen = 1'b1;
         pos_exp = dir_down ? pos0 - run_n : pos0 + run_n;
         chk_word("pos_at_z", pos_exp, cur_pos);
         // Zero offset stops on the Z edge itself
         spd_exp = (cfg.home_offset_setting == 16'h0000) ? 16'h0000 :
                   cfg.creep_speed_setting;
         chk_word("creep", {16'h0, spd_exp}, {16'h0, speed_cmd});
      end
      if (enc_step === 1'b1 && zseen)
         steps++;
      else if (enc_step === 1'b1)
         run_n++;
   end
   // ==========================================================
   // One homing run with random settings, called at a falling edge
   task automatic run_home(logic [1:0] mul, logic [15:0] off);
      int n;
      cfg.homing_mode_setting = DHS_MODE_DOG;
      cfg.homing_direction_setting = 1'($random(seed));
      cfg.proximity_polarity_setting = 1'($random(seed));
      cfg.feed_length_multiplier = mul;
      cfg.return_speed_setting = 16'($random(seed)) | 16'h0100;
      cfg.creep_speed_setting = (16'($random(seed)) & 16'h00ff) | 16'h0001;
      cfg.home_offset_setting = off;
      cfg.home_coordinate_setting = (mul == 2'h2) ? 16'h8000 :
                                    16'($random(seed));
      dog_start = 8'(6 * (1 + ($random(seed) & 3)) + 1 + ($random(seed) & 3));
      pos0 = cur_pos;
      run_n = 0;
      steps = 0;
      zseen = 1'b0;
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
      chk_bit("flag_clear", 1'b0, flag);
      chk_word("ret", {16'h0, cfg.return_speed_setting},
               {16'h0, speed_cmd});
      chk_bit("dir", cfg.homing_direction_setting, dir_down);
      for (n = 0; n < 9000 && busy === 1'b1; n++)
         @(negedge clock);
      chk_bit("busy_end", 1'b0, busy);
      chk_bit("z_dog", 1'b1, zseen);
      chk_word("offset", {16'h0, off}, 32'(steps));
      chk_bit("flag", 1'b1, flag);
      chk_word("stop", 32'h0, {16'h0, speed_cmd});
      chk_word("coord", exp_pos(cfg.home_coordinate_setting, mul),
               cur_pos);
   endtask : run_home
   // Main sequence: refusals, corner offsets, then random runs
   initial
   begin
      repeat (8) @(negedge clock);
      rst_b = 1'b1;
      repeat (3) @(negedge clock);
      chk_word("rst_pos", 32'h0, cur_pos);
      for (int m = 1; m < 16; m++)
      begin
         cfg.homing_mode_setting = 4'(m);
         start = 1'b1;
         @(negedge clock);
         start = 1'b0;
         chk_bit("mode_refused", 1'b0, busy);
      end
      run_home(2'h0, 16'h0000);
      run_home(2'h3, 16'h07d0);
      for (int i = 0; i < 12; i++)
         run_home(2'(i), 16'($random(seed)) & 16'h003f);
      conclude();
   end
endmodule : dhs_homing_seq_tb_top
